// ---- verilog/loop_port_control.sv ----
// Loop port control: arbitration, forced ordered sets and port state requests.
//
// Behaviour
// RULE1 - Arbitrate for the loop while arbitrate request high.
// RULE2 - Arbitration-won output high exactly in won state.
// RULE3 - Dropping arbitrate request releases the loop properly.
// RULE4 - Send-LIP request starts LIP at once, overriding data.
// RULE5 - User holds send-LIP for at least one cycle.
// RULE6 - Each recognised send-LIP yields exactly twelve LIPs.
// RULE7 - Request still high after burst gives another twelve.
// RULE8 - One CLS sent per cycle send-CLS is high.
// RULE9 - Initialize request moves state machine to initialize.
// RULE10 - Participate request moves state machine to participate.
// RULE11 - Nonparticipate request moves state machine to nonparticipate.
// RULE12 - Default-init enters monitoring using preferred address register.
// RULE13 - Default-init acts only while in initializing state.
// RULE14 - Everything synchronous to the single core clock.
// RULE15 - Priority: initialize, default-init, nonparticipate, participate.
// RULE16 - LIP burst beats CLS until the burst completes.
module loop_port_control
    import loop_port_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic srst_in,
    // Wishbone classic slave.
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [loop_port_pkg::WB_ADDR_W-1:0] wb_adr_in,
    input wire logic [loop_port_pkg::WB_SEL_W-1:0] wb_sel_in,
    input wire logic [loop_port_pkg::WB_DATA_W-1:0] wb_dat_in,
    output logic wb_ack_out,
    output logic [loop_port_pkg::WB_DATA_W-1:0] wb_dat_out,
    // Debug requests from user logic.
    input wire logic arb_req_in,
    input wire logic send_lip_in,
    input wire logic send_cls_in,
    output logic arb_won_out,
    // State requests from user logic.
    input wire logic req_initialize_in,
    input wire logic req_participate_in,
    input wire logic req_nonparticipate_in,
    input wire logic req_default_init_in,
    // Events from the loop receiver.
    input wire logic rx_own_arb_in,
    input wire logic rx_cls_in,
    // Transmit selection and port status.
    output logic [1:0] tx_os_out,
    output logic [loop_port_pkg::STATE_W-1:0] lpsm_state_out,
    output logic [loop_port_pkg::LOOP_ADDR_W-1:0] assigned_addr_out
);
    import loop_port_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State record.
    typedef struct packed {
        lpsm_state_t state;
        logic arb_won;
        tx_os_t tx_os;
        logic lip_active;
        logic [LIP_CNT_W-1:0] lip_cnt;
        logic [LOOP_ADDR_W-1:0] pref_addr;
        logic [LOOP_ADDR_W-1:0] assigned_addr;
        logic ack;
        logic [WB_DATA_W-1:0] rdat;
    } ctl_state_t;

    localparam ctl_state_t CTL_RST = '{
        state: ST_INITIALIZE,
        arb_won: 1'b0,
        tx_os: OS_DATA,
        lip_active: 1'b0,
        lip_cnt: '0,
        pref_addr: PREF_ADDR_RST,
        assigned_addr: ASSIGNED_ADDR_RST,
        ack: 1'b0,
        rdat: '0
    };

    ctl_state_t cur_r;
    ctl_state_t cur_nxt;

    logic bus_req;
    logic lip_last;
    logic [WB_DATA_W-1:0] status_word;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        cur_nxt = cur_r;
        bus_req = wb_cyc_in && wb_stb_in && !cur_r.ack;
        lip_last = cur_r.lip_active && (cur_r.lip_cnt == LIP_CNT_LAST);
        status_word = '0;
        status_word[STAT_STATE_LSB +: STATE_W] = cur_r.state;
        status_word[STAT_ARB_WON_BIT] = cur_r.arb_won;
        status_word[STAT_LIP_BIT] = cur_r.lip_active;
        status_word[STAT_ADDR_LSB +: LOOP_ADDR_W] = cur_r.assigned_addr;

        // Bus slave: one wait state, unmapped reads return zero and writes are dropped.
        cur_nxt.ack = bus_req;
        cur_nxt.rdat = '0;
        if (bus_req && wb_we_in) begin
            if (wb_adr_in == REG_PREF_ADDR_OFS && wb_sel_in[PREF_LANE]) begin
                cur_nxt.pref_addr = wb_dat_in[PREF_ADDR_LSB +: LOOP_ADDR_W];
            end
        end else if (bus_req) begin
            case (wb_adr_in)
                REG_STATUS_OFS: begin
                    cur_nxt.rdat = status_word;
                end
                REG_PREF_ADDR_OFS: begin
                    cur_nxt.rdat[PREF_ADDR_LSB +: LOOP_ADDR_W] = cur_r.pref_addr;
                end
                default: begin
                    cur_nxt.rdat = '0;
                end
            endcase
        end

        // LIP bursts: a request seen in any single cycle outside a burst, or in its last cycle, is enough to start one. [RULE5]
        if (lip_last) begin
            if (send_lip_in) begin
                cur_nxt.lip_cnt = '0; // [RULE7]
            end else begin
                cur_nxt.lip_active = 1'b0; // [RULE6]
                cur_nxt.lip_cnt = '0;
            end
        end else if (cur_r.lip_active) begin
            cur_nxt.lip_cnt = cur_r.lip_cnt + LIP_CNT_STEP; // [RULE6]
        end else if (send_lip_in) begin
            cur_nxt.lip_active = 1'b1; // [RULE4]
            cur_nxt.lip_cnt = '0;
        end

        // Port state requests in fixed priority, then the arbitration walk.
        if (req_initialize_in) begin
            cur_nxt.state = ST_INITIALIZE; // [RULE9] [RULE15]
        end else if (req_default_init_in && cur_r.state == ST_INITIALIZE) begin
            cur_nxt.state = ST_MONITORING; // [RULE12] [RULE13] [RULE15]
            cur_nxt.assigned_addr = cur_r.pref_addr; // [RULE12]
        end else if (req_nonparticipate_in) begin
            cur_nxt.state = ST_NONPARTICIPATE; // [RULE11] [RULE15]
        end else if (req_participate_in) begin
            cur_nxt.state = ST_PARTICIPATE; // [RULE10] [RULE15]
        end else begin
            case (cur_r.state)
                ST_MONITORING, ST_PARTICIPATE: begin
                    if (arb_req_in) begin
                        cur_nxt.state = ST_ARBITRATING; // [RULE1]
                    end
                end
                ST_ARBITRATING: begin
                    // Nothing is open yet, so giving up needs no close.
                    if (!arb_req_in) begin
                        cur_nxt.state = ST_MONITORING; // [RULE3]
                    end else if (rx_own_arb_in) begin
                        cur_nxt.state = ST_ARB_WON; // [RULE1]
                    end
                end
                ST_ARB_WON: begin
                    if (!arb_req_in) begin
                        cur_nxt.state = ST_RELEASING; // [RULE3]
                    end
                end
                ST_RELEASING: begin
                    // The loop is only free again once the close comes back round.
                    if (rx_cls_in) begin
                        cur_nxt.state = ST_MONITORING; // [RULE3]
                    end
                end
                default: begin
                    cur_nxt.state = cur_r.state;
                end
            endcase
        end

        cur_nxt.arb_won = (cur_nxt.state == ST_ARB_WON); // [RULE2]

        // Transmit selection: LIP overrides everything, even a frame in flight.
        if (cur_nxt.lip_active) begin
            cur_nxt.tx_os = OS_LIP; // [RULE4] [RULE16]
        end else if (send_cls_in || cur_nxt.state == ST_RELEASING) begin
            cur_nxt.tx_os = OS_CLS; // [RULE8] [RULE3]
        end else if (cur_nxt.state == ST_ARBITRATING) begin
            cur_nxt.tx_os = OS_ARB; // [RULE1]
        end else begin
            cur_nxt.tx_os = OS_DATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register on the one core clock, synchronous reset.
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            cur_r <= CTL_RST; // [RULE14]
        end else begin
            cur_r <= cur_nxt; // [RULE14]
        end
    end

    assign wb_ack_out = cur_r.ack;
    assign wb_dat_out = cur_r.rdat;
    assign arb_won_out = cur_r.arb_won;
    assign tx_os_out = cur_r.tx_os;
    assign lpsm_state_out = cur_r.state;
    assign assigned_addr_out = cur_r.assigned_addr;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    logic no_state_req;
    assign no_state_req = !req_initialize_in && !req_nonparticipate_in && !req_participate_in
        && !(req_default_init_in && cur_r.state == ST_INITIALIZE);

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (srst_in);

    a_arb_start: assert property ( // [RULE1]
        ((cur_r.state == ST_MONITORING || cur_r.state == ST_PARTICIPATE) && arb_req_in && no_state_req)
        |=> (lpsm_state_out == ST_ARBITRATING) && (tx_os_out != OS_DATA))
        else $error("arbitration not started");

    a_won_flag: assert property ( // [RULE2]
        arb_won_out == (lpsm_state_out == ST_ARB_WON))
        else $error("arbitration won flag does not match state");

    a_release_close: assert property ( // [RULE3]
        (cur_r.state == ST_ARB_WON && !arb_req_in && no_state_req && !send_lip_in && !cur_r.lip_active)
        |=> (lpsm_state_out == ST_RELEASING) && (tx_os_out == OS_CLS) && !arb_won_out)
        else $error("loop not released by close");

    a_lip_immediate: assert property ( // [RULE4]
        (!cur_r.lip_active && send_lip_in) |=> (tx_os_out == OS_LIP) [*8])
        else $error("LIP not sent at once");

    a_lip_length: assert property ( // [RULE6]
        $fell(cur_r.lip_active) |-> ($past(cur_r.lip_cnt) == LIP_CNT_LAST) && !$past(send_lip_in))
        else $error("LIP burst ended at wrong count");

    a_lip_repeat: assert property ( // [RULE7]
        (lip_last && send_lip_in) |=> cur_r.lip_active && (cur_r.lip_cnt == '0) && (tx_os_out == OS_LIP))
        else $error("LIP burst not repeated");

    a_cls_each: assert property ( // [RULE8]
        (!cur_r.lip_active && !send_lip_in && send_cls_in) |=> (tx_os_out == OS_CLS))
        else $error("CLS not sent for request cycle");

    a_lip_first: assert property ( // [RULE16]
        cur_r.lip_active |-> (tx_os_out == OS_LIP))
        else $error("CLS sent during LIP burst");

    a_init_req: assert property ( // [RULE9]
        req_initialize_in |=> (lpsm_state_out == ST_INITIALIZE) && !arb_won_out)
        else $error("initialize request ignored");

    a_part_req: assert property ( // [RULE10]
        (req_participate_in && !req_initialize_in && !req_nonparticipate_in
            && !(req_default_init_in && cur_r.state == ST_INITIALIZE))
        |=> (lpsm_state_out == ST_PARTICIPATE))
        else $error("participate request ignored");

    a_nonpart_req: assert property ( // [RULE11] [RULE15]
        (req_nonparticipate_in && !req_initialize_in && !(req_default_init_in && cur_r.state == ST_INITIALIZE))
        |=> (lpsm_state_out == ST_NONPARTICIPATE))
        else $error("nonparticipate request ignored");

    a_default_init: assert property ( // [RULE12] [RULE13]
        (cur_r.state == ST_INITIALIZE && req_default_init_in && !req_initialize_in)
        |=> (lpsm_state_out == ST_MONITORING) && (assigned_addr_out == $past(cur_r.pref_addr)))
        else $error("default init did not adopt preferred address");

    a_default_gated: assert property ( // [RULE13]
        (cur_r.state != ST_INITIALIZE) |=> (assigned_addr_out == $past(assigned_addr_out)))
        else $error("assigned address changed outside initialize");

    a_bus_ack: assert property (
        (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out ##1 !wb_ack_out)
        else $error("bus ack not one cycle after request");

    a_bus_ack_pulse: assert property (
        wb_ack_out |=> !wb_ack_out)
        else $error("bus ack held longer than one cycle");

    a_bus_idle_data: assert property (
        !wb_ack_out |-> (wb_dat_out == '0))
        else $error("read data not zero outside ack");

    a_arb_win: assert property ( // [RULE1]
        (cur_r.state == ST_ARBITRATING && arb_req_in && rx_own_arb_in && no_state_req)
        |=> (lpsm_state_out == ST_ARB_WON) && arb_won_out)
        else $error("arbitration not won on own arbitrate return");

    a_arb_hold: assert property ( // [RULE1]
        (cur_r.state == ST_ARBITRATING && arb_req_in && !rx_own_arb_in && no_state_req)
        |=> (lpsm_state_out == ST_ARBITRATING))
        else $error("arbitration left without cause");

    a_arb_refused: assert property ( // [RULE1]
        ((cur_r.state == ST_INITIALIZE || cur_r.state == ST_NONPARTICIPATE) && no_state_req)
        |=> $stable(lpsm_state_out))
        else $error("state changed without a request");

    a_won_hold: assert property ( // [RULE2]
        (cur_r.state == ST_ARB_WON && arb_req_in && no_state_req) |=> (lpsm_state_out == ST_ARB_WON) && arb_won_out)
        else $error("won state left while request held");

    a_won_tx: assert property ( // [RULE1]
        (lpsm_state_out == ST_ARB_WON) |-> (tx_os_out != OS_ARB))
        else $error("arbitrate fill sent after winning");

    a_arb_abort: assert property ( // [RULE3]
        (cur_r.state == ST_ARBITRATING && !arb_req_in && no_state_req) |=> (lpsm_state_out == ST_MONITORING))
        else $error("withdrawn arbitration did not return to monitoring");

    a_release_wait: assert property ( // [RULE3]
        (cur_r.state == ST_RELEASING && !rx_cls_in && no_state_req)
        |=> (lpsm_state_out == ST_RELEASING) && !arb_won_out)
        else $error("release ended before close returned");

    a_release_done: assert property ( // [RULE3]
        (cur_r.state == ST_RELEASING && rx_cls_in && no_state_req) |=> (lpsm_state_out == ST_MONITORING))
        else $error("release did not end on returned close");

    a_release_tx: assert property ( // [RULE3]
        (lpsm_state_out == ST_RELEASING && !cur_r.lip_active) |-> (tx_os_out == OS_CLS))
        else $error("close not sent while releasing");

    // The burst counter must walk one step per cycle, or the burst length drifts.
    a_lip_step: assert property ( // [RULE6]
        (cur_r.lip_active && !lip_last)
        |=> cur_r.lip_active && (cur_r.lip_cnt == $past(cur_r.lip_cnt) + LIP_CNT_STEP))
        else $error("LIP burst counter skipped");

    a_lip_end: assert property ( // [RULE6]
        (lip_last && !send_lip_in) |=> !cur_r.lip_active)
        else $error("LIP burst ran past twelve");

    a_addr_stable: assert property ( // [RULE12]
        !(cur_r.state == ST_INITIALIZE && req_default_init_in && !req_initialize_in) |=> $stable(assigned_addr_out))
        else $error("assigned address changed without default init");

endmodule : loop_port_control

// ---- verilog/loop_port_pkg.sv ----
// Constants, register map and types shared by the loop port control block.
package loop_port_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus and register map.
    localparam int unsigned WB_ADDR_W = 10;
    localparam int unsigned WB_DATA_W = 32;
    localparam int unsigned WB_SEL_W = 4;
    localparam logic [WB_ADDR_W-1:0] REG_STATUS_OFS = 10'h000;
    localparam logic [WB_ADDR_W-1:0] REG_PREF_ADDR_OFS = 10'h210;

    ////////////////////////////////////////////////////////////////////////////
    // Field layout and reset values.
    localparam int unsigned LOOP_ADDR_W = 8;
    localparam int unsigned STATE_W = 3;
    localparam int unsigned STAT_STATE_LSB = 0;
    localparam int unsigned STAT_ARB_WON_BIT = 3;
    localparam int unsigned STAT_LIP_BIT = 4;
    localparam int unsigned STAT_ADDR_LSB = 8;
    localparam int unsigned PREF_ADDR_LSB = 0;
    localparam int unsigned PREF_LANE = 0;
    localparam logic [LOOP_ADDR_W-1:0] PREF_ADDR_RST = 8'h01;
    localparam logic [LOOP_ADDR_W-1:0] ASSIGNED_ADDR_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Ordered-set burst length.
    localparam int unsigned LIP_CNT_W = 4;
    localparam logic [LIP_CNT_W-1:0] LIP_BURST_LEN = 4'hC;
    localparam logic [LIP_CNT_W-1:0] LIP_CNT_LAST = LIP_BURST_LEN - 4'h1;
    localparam logic [LIP_CNT_W-1:0] LIP_CNT_STEP = 4'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Loop port states, Gray coded along init, monitor, arbitrate, won, release.
    typedef enum logic [STATE_W-1:0] {
        ST_INITIALIZE = 3'h0,
        ST_MONITORING = 3'h1,
        ST_ARBITRATING = 3'h3,
        ST_ARB_WON = 3'h2,
        ST_RELEASING = 3'h6,
        ST_PARTICIPATE = 3'h7,
        ST_NONPARTICIPATE = 3'h5
    } lpsm_state_t;

    // Ordered set chosen for the transmitter in each cycle.
    typedef enum logic [1:0] {
        OS_DATA = 2'h0,
        OS_LIP = 2'h1,
        OS_CLS = 2'h2,
        OS_ARB = 2'h3
    } tx_os_t;

endpackage : loop_port_pkg

// ---- dv/loop_peer_model.sv ----
// Loop-side peer model that answers arbitration and close ordered sets.
module loop_peer_model (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic srst_in,
    // Answer delay in cycles and the observed transmit selection.
    input wire logic [3:0] dly_in,
    input wire logic [1:0] tx_os_in,
    // Receiver events back to the block.
    output logic rx_own_arb_out,
    output logic rx_cls_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import loop_port_pkg::*;
    logic [1:0] last_r;
    logic [4:0] cnt_r;
    logic [4:0] age;
    // The age restarts whenever the ordered set changes, so an answer always follows a fresh run.
    assign age = (tx_os_in == last_r) ? cnt_r + 5'h01 : 5'h00;
    always_ff @(posedge core_clk_in) begin
        last_r <= srst_in ? 2'h0 : tx_os_in;
        cnt_r <= srst_in ? 5'h00 : age;
    end
    assign rx_own_arb_out = (tx_os_in == OS_ARB) && (age == {1'b0, dly_in});
    assign rx_cls_out = (tx_os_in == OS_CLS) && (age == {1'b0, dly_in});
endmodule : loop_peer_model

// ---- dv/testbench.sv ----
// Self-checking bench for the loop port control block.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import loop_port_pkg::*;
    logic core_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
    logic [WB_ADDR_W-1:0] wb_adr_in = '0;
    logic [WB_SEL_W-1:0] wb_sel_in = '0;
    logic [WB_DATA_W-1:0] wb_dat_in = '0;
    logic [WB_DATA_W-1:0] wb_dat_out;
    logic wb_ack_out, arb_won_out, rx_own_arb, rx_cls;
    logic arb_req_in = 1'b0, send_lip_in = 1'b0, send_cls_in = 1'b0;
    // Order is initialize, default-init, nonparticipate, participate.
    logic [3:0] req_vec = 4'h0;
    logic [3:0] dly = 4'h0;
    logic [1:0] tx_os_out;
    logic [STATE_W-1:0] lpsm_state_out;
    logic [LOOP_ADDR_W-1:0] assigned_addr_out;
    int fail_count = 0, checked = 0, seed = 40665, n, len;
    logic [31:0] rd;
    logic [7:0] pref_m;
    int hold [3] = '{1, 12, 0};
    logic [3:0] pat [7] = '{4'h1, 4'h4, 4'h3, 4'hA, 4'h7, 4'hC, 4'h4};
    lpsm_state_t exp_st [7] = '{ST_PARTICIPATE, ST_PARTICIPATE, ST_NONPARTICIPATE, ST_INITIALIZE,
                                ST_MONITORING, ST_INITIALIZE, ST_MONITORING};
    initial forever #20 core_clk_in = ~core_clk_in;
    loop_port_control dut (.core_clk_in(core_clk_in), .srst_in(srst_in), .wb_cyc_in(wb_cyc_in),
        .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
        .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out), .arb_req_in(arb_req_in),
        .send_lip_in(send_lip_in), .send_cls_in(send_cls_in), .arb_won_out(arb_won_out),
        .req_initialize_in(req_vec[3]), .req_default_init_in(req_vec[2]),
        .req_nonparticipate_in(req_vec[1]), .req_participate_in(req_vec[0]), .rx_own_arb_in(rx_own_arb),
        .rx_cls_in(rx_cls), .tx_os_out(tx_os_out), .lpsm_state_out(lpsm_state_out),
        .assigned_addr_out(assigned_addr_out));
    loop_peer_model peer (.core_clk_in(core_clk_in), .srst_in(srst_in), .dly_in(dly), .tx_os_in(tx_os_out),
        .rx_own_arb_out(rx_own_arb), .rx_cls_out(rx_cls));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic nxt;
        @(posedge core_clk_in);
        #1;
    endtask : nxt
    task automatic wait_st(input lpsm_state_t s);
        for (n = 0; n < 30 && lpsm_state_out !== s; n++) nxt();
    endtask : wait_st
    task automatic wb(input logic we, input logic [9:0] adr, input logic [3:0] sel, input logic [31:0] wd);
        int k;
        @(posedge core_clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= adr;
        wb_sel_in <= sel;
        wb_dat_in <= wd;
        // The data is taken one time unit after the edge that raises ack, where it has already settled.
        for (k = 0; k < 20 && wb_ack_out !== 1'b1; k++) nxt();
        if (wb_ack_out !== 1'b1) fail_count++;
        rd = wb_dat_out;
        @(posedge core_clk_in);
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        wb_we_in <= 1'b0;
    endtask : wb
    task automatic finish_test;
        if (fail_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        fail_count++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge core_clk_in);
        srst_in <= 1'b0;
        nxt();
        chk(lpsm_state_out, ST_INITIALIZE);
        wb(1'b0, REG_STATUS_OFS, 4'hF, 32'h0);
        chk(rd, {16'h0, ASSIGNED_ADDR_RST, 8'h00});
        wb(1'b0, REG_PREF_ADDR_OFS, 4'hF, 32'h0);
        chk(rd, {24'h0, PREF_ADDR_RST});
        pref_m = 8'($random(seed));
        wb(1'b1, REG_PREF_ADDR_OFS, 4'h1, {24'h0, pref_m});
        wb(1'b1, REG_PREF_ADDR_OFS, 4'hE, {24'h0, ~pref_m});
        wb(1'b1, 10'h104, 4'hF, 32'hFFFFFFFF);
        wb(1'b0, 10'h104, 4'hF, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, REG_PREF_ADDR_OFS, 4'hF, 32'h0);
        chk(rd, {24'h0, pref_m});
        foreach (pat[i]) begin
            @(posedge core_clk_in);
            req_vec <= pat[i];
            nxt();
            chk(lpsm_state_out, exp_st[i]);
            if (exp_st[i] == ST_MONITORING) chk(assigned_addr_out, pref_m);
        end
        @(posedge core_clk_in);
        req_vec <= 4'h0;
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk_in);
            dly <= 4'(5 * k);
            arb_req_in <= 1'b1;
            nxt();
            chk(lpsm_state_out, ST_ARBITRATING);
            chk(tx_os_out, OS_ARB);
            wait_st(ST_ARB_WON);
            chk(32'(n), 32'(5 * k + 1));
            chk(arb_won_out, 1'b1);
            chk(tx_os_out, OS_DATA);
            wb(1'b0, REG_STATUS_OFS, 4'hF, 32'h0);
            chk(rd, {16'h0, pref_m, 8'h0A});
            @(posedge core_clk_in);
            arb_req_in <= 1'b0;
            nxt();
            chk({arb_won_out, tx_os_out, lpsm_state_out}, {1'b0, OS_CLS, ST_RELEASING});
            wait_st(ST_MONITORING);
            chk(32'(n), 32'(5 * k + 1));
            chk(tx_os_out, OS_DATA);
        end
        // A slow peer lets the request be withdrawn before the loop is won.
        @(posedge core_clk_in);
        dly <= 4'hF;
        arb_req_in <= 1'b1;
        nxt();
        chk(lpsm_state_out, ST_ARBITRATING);
        @(posedge core_clk_in);
        arb_req_in <= 1'b0;
        nxt();
        chk({arb_won_out, lpsm_state_out}, {1'b0, ST_MONITORING});
        hold[2] = 1 + ($unsigned($random(seed)) % 23);
        foreach (hold[i]) begin
            @(posedge core_clk_in);
            send_lip_in <= 1'b1;
            send_cls_in <= 1'b1;
            for (int c = 1; c <= 12 * (1 + (hold[i] - 1) / 12); c++) begin
                @(posedge core_clk_in);
                if (c == hold[i]) send_lip_in <= 1'b0;
                #1;
                chk(tx_os_out, OS_LIP);
            end
            len = 1 + ($unsigned($random(seed)) % 5);
            for (int c = 1; c <= len; c++) begin
                @(posedge core_clk_in);
                if (c == len) send_cls_in <= 1'b0;
                #1;
                chk(tx_os_out, OS_CLS);
            end
            nxt();
            chk(tx_os_out, OS_DATA);
        end
        finish_test();
    end
endmodule : testbench
